// *** design/sadcc_ctrl.sv ***
`timescale 1ns/1ps
module sadcc_ctrl
  import sadcc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Host pins
  input  wire logic              chipSelect_n,
  input  wire logic              startConvert_n,
  input  wire logic              outputEnable_n,
  input  wire logic              byteSelect_n,
  input  wire logic              eocEnable_n,
  // Straps
  input  wire logic              syncMode,
  input  wire logic              bipolarOffsetPin,
  // Converter core
  input  wire logic [RES_W-1:0]  rawCode,
  output logic                   sampleHold,
  // Result bus
  output logic [BYTE_W-1:0]      resultByte,
  output logic                   resultByteOe_n,
  // Conversion status
  output logic                   convDone,
  output logic                   convDoneOe_n
);

  logic              csSync;
  logic              startSync;
  logic              oeSync;
  logic              bselSync;
  logic              eocEnSync;
  logic              modeSync;
  logic              bipSync;
  logic              startPrev_q;
  logic              startFall;
  logic              startReq;
  sadcc_state_t      state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [WORD_W-1:0] result_q;
  logic [RES_W-1:0]  coded;
  logic [CNT_W-1:0]  trackCnt_q;

  localparam int HOLD_MAX  = HOLD_CYC;
  localparam int TRACK_MIN = TRACK_MARGIN_CYC + 1;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  sadcc_sync u_sync_cs (
    .clk     (clk),
    .srst    (srst),
    .asyncIn (chipSelect_n),
    .syncOut (csSync)
  );
  sadcc_sync u_sync_start (
    .clk     (clk),
    .srst    (srst),
    .asyncIn (startConvert_n),
    .syncOut (startSync)
  );
  sadcc_sync u_sync_oe (
    .clk     (clk),
    .srst    (srst),
    .asyncIn (outputEnable_n),
    .syncOut (oeSync)
  );
  sadcc_sync u_sync_bsel (
    .clk     (clk),
    .srst    (srst),
    .asyncIn (byteSelect_n),
    .syncOut (bselSync)
  );
  sadcc_sync u_sync_eoc (
    .clk     (clk),
    .srst    (srst),
    .asyncIn (eocEnable_n),
    .syncOut (eocEnSync)
  );
  sadcc_sync u_sync_mode (
    .clk     (clk),
    .srst    (srst),
    .asyncIn (syncMode),
    .syncOut (modeSync)
  );
  sadcc_sync u_sync_bip (
    .clk     (clk),
    .srst    (srst),
    .asyncIn (bipolarOffsetPin),
    .syncOut (bipSync)
  );

  // ****************************************************************
  // Start detection
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      startPrev_q <= 1'b1;
    end else begin
      startPrev_q <= startSync;
    end
  end

  assign startFall = startPrev_q & ~startSync;
  assign startReq = startFall & (~modeSync | ~csSync);

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= SADCC_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        SADCC_IDLE: begin
          if (startReq) begin
            state_q <= SADCC_HOLD;
            cnt_q   <= '0;
          end
        end
        SADCC_HOLD: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(HOLD_CYC - 1)) begin
            state_q <= SADCC_TRACK;
          end
        end
        SADCC_TRACK: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(CONV_CYC - 1)) begin
            state_q <= SADCC_IDLE;
          end
        end
        default: begin
          state_q <= SADCC_IDLE;
        end
      endcase
    end
  end

  assign sampleHold = (state_q == SADCC_HOLD);

  // ****************************************************************
  // Result register
  // ****************************************************************
  assign coded = bipSync ? {~rawCode[RES_MSB], rawCode[RES_MSB-1:0]}
                         : rawCode;

  always_ff @(posedge clk) begin
    if (srst) begin
      result_q <= '0;
    end else if (state_q == SADCC_TRACK &&
                 cnt_q == CNT_W'(CONV_CYC - 1)) begin
      result_q <= {coded, {PAD_W{1'b0}}};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      resultByte <= '0;
    end else begin
      resultByte <= bselSync ? result_q[BYTE_W-1:0]
                             : result_q[WORD_W-1:BYTE_W];
    end
  end

  assign resultByteOe_n = csSync | oeSync;

  // ****************************************************************
  // Conversion status pin
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      convDone <= 1'b1;
    end else begin
      convDone <= ~startReq & (state_q == SADCC_IDLE);
    end
  end

  assign convDoneOe_n = modeSync ? (eocEnSync | csSync)
                                 : (eocEnSync | convDone);

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_sync_gate;
    @(posedge clk) disable iff (srst)
      (modeSync && csSync && state_q == SADCC_IDLE) |=> state_q == SADCC_IDLE;
  endproperty
  a_sync_gate: assert property (p_sync_gate)
    else $error("start accepted with chip select high");

  property p_async_start;
    @(posedge clk) disable iff (srst)
      (!modeSync && startFall && state_q == SADCC_IDLE) |=> sampleHold;
  endproperty
  a_async_start: assert property (p_async_start)
    else $error("async falling edge did not start");

  property p_no_start_high;
    @(posedge clk) disable iff (srst)
      (startSync && state_q == SADCC_IDLE) |=> state_q == SADCC_IDLE;
  endproperty
  a_no_start_high: assert property (p_no_start_high)
    else $error("start without falling edge");

  property p_done_low;
    @(posedge clk) disable iff (srst)
      $rose(sampleHold) |-> !convDone;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("status not low at start");

  property p_idle_track;
    @(posedge clk) disable iff (srst)
      convDone |-> !sampleHold;
  endproperty
  a_idle_track: assert property (p_idle_track)
    else $error("holding while idle");

  property p_retrack;
    @(posedge clk) disable iff (srst)
      $rose(sampleHold) |-> ##[1:HOLD_MAX] !sampleHold;
  endproperty
  a_retrack: assert property (p_retrack)
    else $error("sampler not retracking in time");

  // Track cycles since the last hold, saturating
  always_ff @(posedge clk) begin
    if (srst) begin
      trackCnt_q <= CNT_W'(TRACK_MIN);
    end else if (sampleHold) begin
      trackCnt_q <= '0;
    end else if (trackCnt_q != CNT_W'(TRACK_MIN)) begin
      trackCnt_q <= trackCnt_q + 1'b1;
    end
  end

  property p_track_margin;
    @(posedge clk) disable iff (srst)
      $rose(sampleHold) |-> trackCnt_q == CNT_W'(TRACK_MIN);
  endproperty
  a_track_margin: assert property (p_track_margin)
    else $error("hold began before enough tracking");

  property p_read_drive;
    @(posedge clk) disable iff (srst)
      (!csSync && !oeSync) |-> !resultByteOe_n;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("result not driven");

  property p_low_pad;
    @(posedge clk) disable iff (srst)
      $past(bselSync) |-> resultByte[PAD_W-1:0] == '0;
  endproperty
  a_low_pad: assert property (p_low_pad)
    else $error("low byte pad bits not zero");

  property p_eoc_gate;
    @(posedge clk) disable iff (srst)
      (modeSync && csSync) |-> convDoneOe_n;
  endproperty
  a_eoc_gate: assert property (p_eoc_gate)
    else $error("status driven with chip select high");

endmodule

// *** common/sadcc_pkg.sv ***
package sadcc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 20;
  localparam int SETTLE_NS       = 1500;
  localparam int TRACK_MARGIN_NS = 2000;
  localparam int CONV_NS         = 7800;
  localparam int SETTLE_CYC      = SETTLE_NS / CLK_PERIOD_NS;
  localparam int TRACK_MARGIN_CYC =
    (TRACK_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC        = CONV_NS / CLK_PERIOD_NS;
  localparam int HOLD_CYC        = CONV_CYC - TRACK_MARGIN_CYC - 1;
  localparam int CNT_W           = 9;

  // ****************************************************************
  // Result layout
  // ****************************************************************
  localparam int RES_W      = 14;
  localparam int WORD_W     = 16;
  localparam int BYTE_W     = 8;
  localparam int RES_MSB    = 13;
  localparam int PAD_W      = 2;
  localparam int SYNC_DEPTH = 2;

  // ****************************************************************
  // Converter states
  // ****************************************************************
  typedef enum logic [1:0] {
    SADCC_IDLE  = 2'b00,
    SADCC_HOLD  = 2'b01,
    SADCC_TRACK = 2'b10
  } sadcc_state_t;

endpackage

// *** design/sadcc_sync.sv ***
`timescale 1ns/1ps
module sadcc_sync
  import sadcc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Async level in, synced level out
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic [SYNC_DEPTH-1:0] stage_q;

  // ****************************************************************
  // Two flop synchroniser
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      stage_q <= '1;
    end else begin
      stage_q <= {stage_q[0], asyncIn};
    end
  end

  assign syncOut = stage_q[SYNC_DEPTH-1];

endmodule

// *** tb/sadcc_host.sv ***
`timescale 1ns/1ps
module sadcc_host (
  // Clock
  input  wire logic       clk,
  // Host pins
  output logic            chipSelect_n,
  output logic            startConvert_n,
  output logic            outputEnable_n,
  output logic            byteSelect_n,
  output logic            eocEnable_n,
  // Result bus
  input  wire logic [7:0] resultByte,
  input  wire logic       resultByteOe_n
);
  initial begin
    chipSelect_n = 1'b1;
    startConvert_n = 1'b1;
    outputEnable_n = 1'b1;
    byteSelect_n = 1'b0;
    eocEnable_n = 1'b0;
  end

  // ****************************************************************
  // Start pulse, select first
  // ****************************************************************
  task automatic startConv(input logic useCs);
    @(negedge clk) chipSelect_n = ~useCs;
    @(negedge clk) startConvert_n = 1'b0;
    repeat (4) @(negedge clk);
    startConvert_n = 1'b1;
    chipSelect_n = 1'b1;
  endtask

  // ****************************************************************
  // One byte read
  // ****************************************************************
  task automatic readByte(input logic lowSel, output logic [7:0] b,
                          output logic en);
    @(negedge clk) chipSelect_n = 1'b0;
    byteSelect_n = lowSel;
    @(negedge clk) outputEnable_n = 1'b0;
    repeat (4) @(negedge clk);
    b = resultByte;
    en = resultByteOe_n;
    outputEnable_n = 1'b1;
    chipSelect_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  // ****************************************************************
  // Status enable level
  // ****************************************************************
  task automatic setStatusEn(input logic enN);
    @(negedge clk) eocEnable_n = enN;
  endtask
endmodule

// *** tb/sadcc_ctrl_bench.sv ***
`timescale 1ns/1ps
module sadcc_ctrl_bench;
  import sadcc_pkg::*;
  logic             clk = 1'b0;
  logic             srst = 1'b1;
  logic             syncMode = 1'b1;
  logic             bip = 1'b0;
  logic [RES_W-1:0] rawCode = '0;
  logic             csN, startN, oeN, bselN, eocN;
  logic [7:0]       resultByte;
  logic             resultByteOe_n, sampleHold, convDone, convDoneOe_n;
  logic [31:0]      seed = 32'hf39a;
  int               fails = 0;
  int               nTests = 0;
  int               nh = 0;
  int               nl = 0;

  always #10 clk = ~clk;
  always @(posedge clk) begin
    nh <= nh + int'(sampleHold === 1'b1);
    nl <= nl + int'(convDone === 1'b0);
  end

  sadcc_host u_host (.clk(clk), .chipSelect_n(csN), .startConvert_n(startN),
    .outputEnable_n(oeN), .byteSelect_n(bselN), .eocEnable_n(eocN),
    .resultByte(resultByte), .resultByteOe_n(resultByteOe_n));
  sadcc_ctrl u_dut (.clk(clk), .srst(srst), .chipSelect_n(csN),
    .startConvert_n(startN), .outputEnable_n(oeN), .byteSelect_n(bselN),
    .eocEnable_n(eocN), .syncMode(syncMode), .bipolarOffsetPin(bip),
    .rawCode(rawCode), .sampleHold(sampleHold), .resultByte(resultByte),
    .resultByteOe_n(resultByteOe_n), .convDone(convDone),
    .convDoneOe_n(convDoneOe_n));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [15:0] expWord(input logic [13:0] c,
                                          input logic b);
    return {b ? 14'(c - (14'h1 << RES_MSB)) : c, 2'h0};
  endfunction
  task automatic chkBit(input string nm, input logic e, input logic g);
    nTests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chkVal(input string nm, input logic [15:0] e,
                        input logic [15:0] g);
    nTests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tallyAndFinish();
    $display("checks %0d fails %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    logic [15:0] w;
    logic [7:0]  b;
    logic        en;
    int          i;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chkBit("idleDone", 1'b1, convDone);
    chkBit("idleTrack", 1'b0, sampleHold);
    u_host.startConv(1'b0);
    repeat (10) @(negedge clk);
    chkBit("csHighStart", 1'b1, convDone);
    for (int t = 0; t < 6; t++) begin
      seed = xs(seed);
      syncMode = t[0];
      bip = t[1];
      rawCode = (t == 0) ? '0 : (t == 1) ? '1 : seed[RES_W-1:0];
      w = expWord(rawCode, bip);
      nh = 0;
      nl = 0;
      u_host.startConv(syncMode);
      chkBit("heldAtSwitch", 1'b1, sampleHold);
      repeat (5) @(negedge clk);
      chkBit("statusOe", syncMode, convDoneOe_n);
      u_host.setStatusEn(1'b1);
      repeat (3) @(negedge clk);
      chkBit("statusOff", 1'b1, convDoneOe_n);
      u_host.setStatusEn(1'b0);
      for (i = 0; i < 500 && convDone !== 1'b1; i++) @(negedge clk);
      chkBit("statusIdle", 1'b1, convDoneOe_n);
      chkVal("convLen", 16'(CONV_CYC + 1), 16'(nl));
      chkVal("holdLen", 16'(HOLD_CYC), 16'(nh));
      chkBit("trackTime", 1'b1, (nl - nh) > TRACK_MARGIN_CYC);
      u_host.readByte(1'b0, b, en);
      chkVal("hiByte", {8'h00, w[15:8]}, {8'h00, b});
      chkBit("dataOe", 1'b0, en);
      u_host.readByte(1'b1, b, en);
      chkVal("loByte", {8'h00, w[7:0]}, {8'h00, b});
      chkBit("dataOff", 1'b1, resultByteOe_n);
      $display("test %0d done", t);
    end
    u_host.startConv(1'b1);
    repeat (20) @(negedge clk);
    srst = 1'b1;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chkBit("rstDone", 1'b1, convDone);
    chkBit("rstTrack", 1'b0, sampleHold);
    chkVal("rstData", 16'h0000, {8'h00, resultByte});
    u_host.startConv(1'b1);
    repeat (5) @(negedge clk);
    chkBit("rstStart", 1'b0, convDone);
    $display("test reset done");
    tallyAndFinish();
  end

  initial begin
    repeat (16 * (CONV_CYC + 100)) @(posedge clk);
    fails++;
    tallyAndFinish();
  end
endmodule
